/* logic/svm_pkg.sv */
// package: register map, field layout, types and timing of the supply monitor
package svm_pkg;

	// clock and delay timing
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned IRQ_ASSERT_DELAY_US = 60;
	localparam int unsigned IRQ_ASSERT_DELAY_CYCLES =
		IRQ_ASSERT_DELAY_US * (CLK_FREQ_HZ / 1_000_000);

	// byte offsets on the register bus
	localparam logic [7:0] OFS_DETECT_CONTROL = 8'h00;
	localparam logic [7:0] OFS_IRQ_CONTROL_TWO = 8'h04;
	localparam logic [7:0] OFS_GLOBAL_CONTROL = 8'h08;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h0C;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h10;
	localparam logic [7:0] OFS_THRESHOLD_MV = 8'h14;

	// detect control fields
	localparam int unsigned CTL_THRESH_LSB = 0;
	localparam int unsigned CTL_THRESH_W = 3;
	localparam int unsigned CTL_BANDGAP_BIT = 3;
	localparam int unsigned CTL_ENABLE_BIT = 4;
	localparam int unsigned CTL_OUTPUT_BIT = 5;

	// irq control two and global control fields
	localparam int unsigned IRQ2_FLAG_BIT = 4;
	localparam int unsigned IRQ2_ENABLE_BIT = 0;
	localparam int unsigned GLB_IRQ_EN_BIT = 0;

	// event status and mask layout
	localparam int unsigned EVT_W = 3;
	localparam int unsigned EVT_IRQ_FLAG = 0;
	localparam int unsigned EVT_LOW_RISE = 1;
	localparam int unsigned EVT_LOW_FALL = 2;

	// values after reset
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	// trip level in millivolts for each threshold code
	localparam logic [15:0] THRESH_MV [0:7] = '{
		16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
		16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0
	};

	typedef enum logic [3:0] {
		SVM_MODE_FAST  = 4'h1,
		SVM_MODE_SLOW  = 4'h2,
		SVM_MODE_IDLE  = 4'h4,
		SVM_MODE_SLEEP = 4'h8
	} svm_mode_e;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [7:0]  address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} svm_avm_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} svm_avm_rsp_s;

	typedef struct packed {
		logic       detector_on;
		logic       bandgap_on;
		logic [2:0] threshold_sel;
	} svm_analog_s;

endpackage

/* logic/svm_sync.sv */
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module svm_sync
	import svm_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage_one;

	if (WIDTH < 1) begin : g_chk
		$error("svm_sync: WIDTH must be at least 1");
	end

	// stage_one is read by the second flop only
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stage_one <= '0;
			sync_o    <= '0;
		end else if (ce_i) begin
			stage_one <= async_i;
			sync_o    <= stage_one;
		end
	end
endmodule
`default_nettype wire

/* logic/svm_delay.sv */
// hold-off timer: one pulse once its arm level has stayed high long enough
`timescale 1ns/1ps
`default_nettype none
module svm_delay
	import svm_pkg::*;
#(
	parameter int unsigned CYCLES = IRQ_ASSERT_DELAY_CYCLES
) (
	input  wire logic core_clk_i,
	input  wire logic reset_n_i,
	input  wire logic ce_i,
	input  wire logic arm_i,
	output logic      done_o
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] count;
	logic          spent;

	if (CYCLES < 1) begin : g_chk
		$error("svm_delay: CYCLES must be at least 1");
	end

	// dropping arm restarts the wait, so a glitch never fires
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count <= '0;
			spent <= 1'b0;
		end else if (ce_i) begin
			if (!arm_i) begin
				count <= '0;
				spent <= 1'b0;
			end else if (!spent) begin
				if (count == LAST) begin
					spent <= 1'b1;
				end else begin
					count <= count + CW'(1);
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= arm_i && !spent && (count == LAST);
		end
	end
endmodule
`default_nettype wire

/* logic/svm_top.sv */
// supply voltage monitor: control registers, flag logic and interrupt request
//
// How it works
// - three select bits pick one of eight trip levels, 2.0 V up to 4.0 V
// - output flag reads one while supply is below the level, else zero
// - enable bit one turns detector on, zero switches it off
// - enable works in fast, slow and idle; sleep forces the detector off
// - bandgap on when detector, low voltage reset or buffer bit enabled
// - control bits seven and six are unimplemented and read zero
// - request flag sets after a fixed delay of flag staying high, or by a software write
// - a request flag newly set by the timer produces a wake-up from idle
// - every flag transition near the threshold passes through, none latched
// - request flag at bit four, its enable at bit zero, of irq control two
// - no interrupt leaves the block while the global enable is clear
`timescale 1ns/1ps
`default_nettype none
module svm_top
	import svm_pkg::*;
#(
	parameter int unsigned IRQ_DELAY_CYCLES = IRQ_ASSERT_DELAY_CYCLES
) (
	input  wire logic         core_clk_i,
	input  wire logic         reset_n_i,
	input  wire logic         ce_i,
	input  wire svm_avm_req_s avm_i,
	output var  svm_avm_rsp_s avm_o,
	input  wire svm_mode_e    power_mode_i,
	input  wire logic         lvr_enable_i,
	input  wire logic         comp_below_i,
	output var  svm_analog_s  analog_o,
	output logic              wake_o,
	output logic              lvd_irq_o,
	output logic              irq_o
);

	if (IRQ_DELAY_CYCLES < 1) begin : g_chk
		$error("svm_top: IRQ_DELAY_CYCLES must be at least 1");
	end

	// software state
	logic [CTL_THRESH_W-1:0] threshold_select;
	logic                    detector_enable;
	logic                    bandgap_buffer_enable;
	logic                    low_supply_irq_flag;
	logic                    low_supply_irq_enable;
	logic                    global_irq_enable;
	logic [EVT_W-1:0]        event_status;
	logic [EVT_W-1:0]        event_mask;

	// hardware state
	logic             below_sync;
	logic             low_supply_output_flag;
	logic             flag_prev;
	logic             delay_done;
	logic             detector_on;
	logic             in_sleep;
	logic             in_idle;
	logic [EVT_W-1:0] event_set;

	// bus state
	logic        ack;
	logic        req;
	logic        wr_fire;
	logic        wr_lane0;
	logic [7:0]  wdata;
	logic [5:0]  word_sel;
	logic [31:0] rd_word;
	logic [31:0] readdata;

	// power mode decode
	always_comb begin
		in_sleep = 1'b0;
		in_idle  = 1'b0;
		unique case (power_mode_i)
			SVM_MODE_FAST: begin
				in_sleep = 1'b0;
			end
			SVM_MODE_SLOW: begin
				in_sleep = 1'b0;
			end
			SVM_MODE_IDLE: begin
				in_idle = 1'b1;
			end
			SVM_MODE_SLEEP: begin
				in_sleep = 1'b1;
			end
			default: begin
				// a broken mode code is treated as the safe, quiet state
				in_sleep = 1'b1;
			end
		endcase
	end

	assign detector_on = detector_enable && !in_sleep;

	// comparator crossing into the clock domain
	svm_sync #(
		.WIDTH (1)
	) u_sync (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.ce_i       (ce_i),
		.async_i    (comp_below_i),
		.sync_o     (below_sync)
	);

	// output flag follows the synced comparator each cycle
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_supply_output_flag <= 1'b0;
			flag_prev              <= 1'b0;
		end else if (ce_i) begin
			// a switched-off detector reports no low supply
			low_supply_output_flag <= detector_on && below_sync;
			flag_prev              <= low_supply_output_flag;
		end
	end

	// hold-off before the request flag may set
	svm_delay #(
		.CYCLES (IRQ_DELAY_CYCLES)
	) u_delay (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.ce_i       (ce_i),
		.arm_i      (low_supply_output_flag),
		.done_o     (delay_done)
	);

	// avalon slave: one wait state, then the answer
	assign req      = avm_i.read || avm_i.write;
	assign wr_fire  = avm_i.write && ack && ce_i;
	assign wr_lane0 = wr_fire && avm_i.byteenable[0];
	assign wdata    = avm_i.writedata[7:0];
	assign word_sel = avm_i.address[7:2];

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack <= 1'b0;
		end else if (ce_i) begin
			ack <= req && !ack;
		end
	end

	// waitrequest also holds while frozen so no write is lost
	always_comb begin
		avm_o.waitrequest = !(ack && ce_i);
		avm_o.readdata    = readdata;
	end

	// detect control register
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			threshold_select      <= CTL_RESET[CTL_THRESH_W-1:0];
			bandgap_buffer_enable <= CTL_RESET[CTL_BANDGAP_BIT];
			detector_enable       <= CTL_RESET[CTL_ENABLE_BIT];
		end else if (wr_lane0 &&
			(avm_i.address[7:2] == OFS_DETECT_CONTROL[7:2])) begin
			threshold_select <=
				wdata[CTL_THRESH_LSB +: CTL_THRESH_W];
			bandgap_buffer_enable <= wdata[CTL_BANDGAP_BIT];
			detector_enable       <= wdata[CTL_ENABLE_BIT];
		end
	end

	// request flag: the timer's set wins over a software clear
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_supply_irq_flag <= 1'b0;
		end else if (ce_i) begin
			if (delay_done) begin
				low_supply_irq_flag <= 1'b1;
			end else if (wr_lane0 &&
				(word_sel == OFS_IRQ_CONTROL_TWO[7:2])) begin
				low_supply_irq_flag <= wdata[IRQ2_FLAG_BIT];
			end
		end
	end

	// request enable
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_supply_irq_enable <= 1'b0;
		end else if (wr_lane0 &&
			(word_sel == OFS_IRQ_CONTROL_TWO[7:2])) begin
			low_supply_irq_enable <= wdata[IRQ2_ENABLE_BIT];
		end
	end

	// global enable
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			global_irq_enable <= 1'b0;
		end else if (wr_lane0 &&
			(word_sel == OFS_GLOBAL_CONTROL[7:2])) begin
			global_irq_enable <= wdata[GLB_IRQ_EN_BIT];
		end
	end

	// sticky events, one per bit
	always_comb begin
		event_set               = '0;
		event_set[EVT_IRQ_FLAG] = delay_done && !low_supply_irq_flag;
		event_set[EVT_LOW_RISE] = low_supply_output_flag && !flag_prev;
		event_set[EVT_LOW_FALL] = !low_supply_output_flag && flag_prev;
	end

	for (genvar gi = 0; gi < EVT_W; gi++) begin : g_evt
		always_ff @(posedge core_clk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				event_status[gi] <= EVT_RESET[gi];
			end else if (ce_i) begin
				if (event_set[gi]) begin
					// set beats a write-one clear in the same cycle
					event_status[gi] <= 1'b1;
				end else if (wr_lane0 && wdata[gi] &&
					(word_sel == OFS_EVENT_STATUS[7:2])) begin
					event_status[gi] <= 1'b0;
				end
			end
		end
	end

	// event mask
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			event_mask <= EVT_RESET;
		end else if (wr_lane0 &&
			(word_sel == OFS_EVENT_MASK[7:2])) begin
			event_mask <= wdata[EVT_W-1:0];
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		rd_word = RDATA_RESET;
		unique case (word_sel)
			OFS_DETECT_CONTROL[7:2]: begin
				// bits seven and six stay zero
				rd_word[CTL_THRESH_LSB +: CTL_THRESH_W] =
					threshold_select;
				rd_word[CTL_BANDGAP_BIT] = bandgap_buffer_enable;
				rd_word[CTL_ENABLE_BIT]  = detector_enable;
				rd_word[CTL_OUTPUT_BIT]  = low_supply_output_flag;
			end
			OFS_IRQ_CONTROL_TWO[7:2]: begin
				rd_word[IRQ2_FLAG_BIT]   = low_supply_irq_flag;
				rd_word[IRQ2_ENABLE_BIT] = low_supply_irq_enable;
			end
			OFS_GLOBAL_CONTROL[7:2]: begin
				rd_word[GLB_IRQ_EN_BIT] = global_irq_enable;
			end
			OFS_EVENT_STATUS[7:2]: begin
				rd_word[EVT_W-1:0] = event_status;
			end
			OFS_EVENT_MASK[7:2]: begin
				rd_word[EVT_W-1:0] = event_mask;
			end
			OFS_THRESHOLD_MV[7:2]: begin
				rd_word[15:0] = THRESH_MV[threshold_select];
			end
			default: begin
				rd_word = RDATA_RESET;
			end
		endcase
	end

	// read data captured at the edge that ends the wait state
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			readdata <= RDATA_RESET;
		end else if (ce_i && avm_i.read && !ack) begin
			readdata <= rd_word;
		end
	end

	// analog controls from flops, so the pins never glitch
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			analog_o <= '0;
		end else if (ce_i) begin
			analog_o.detector_on   <= detector_on;
			analog_o.bandgap_on    <= detector_on || lvr_enable_i ||
				bandgap_buffer_enable;
			analog_o.threshold_sel <= threshold_select;
		end
	end

	// wake only on a fresh set; a preset flag keeps the core asleep
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wake_o <= 1'b0;
		end else if (ce_i) begin
			wake_o <= delay_done && !low_supply_irq_flag && in_idle;
		end
	end

	// interrupt outputs, both gated by the global enable
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lvd_irq_o <= 1'b0;
			irq_o     <= 1'b0;
		end else if (ce_i) begin
			lvd_irq_o <= global_irq_enable && low_supply_irq_enable &&
				low_supply_irq_flag;
			irq_o     <= global_irq_enable &&
				(|(event_status & event_mask));
		end
	end

endmodule
`default_nettype wire

/* bench/svm_props.sv */
// checker: concurrent properties on the supply monitor ports
`timescale 1ns/1ps
`default_nettype none
module svm_props
	import svm_pkg::*;
#(
	parameter int unsigned IRQ_DELAY_CYCLES = IRQ_ASSERT_DELAY_CYCLES
) (
	input wire logic         core_clk_i,
	input wire logic         reset_n_i,
	input wire logic         ce_i,
	input wire svm_avm_req_s avm_i,
	input wire svm_avm_rsp_s avm_o,
	input wire svm_mode_e    power_mode_i,
	input wire logic         lvr_enable_i,
	input wire logic         comp_below_i,
	input wire svm_analog_s  analog_o,
	input wire logic         wake_o,
	input wire logic         lvd_irq_o,
	input wire logic         irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	// cycles of steady low supply under an enabled detector; a lower bound
	// only, since the sync chain and flag flop add a few more
	logic [15:0] low_cnt;
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			low_cnt <= '0;
		else if (comp_below_i && analog_o.detector_on)
			low_cnt <= low_cnt + 16'(low_cnt != 16'hFFFF);
		else
			low_cnt <= '0;
	end

	// accepted write to a word; waitrequest low implies a running clock
	sequence s_wr(a);
		avm_i.write && !avm_o.waitrequest && avm_i.byteenable[0] &&
			avm_i.address[7:2] == a;
	endsequence
	sequence s_wr_off(a);
		s_wr(a) ##0 !avm_i.writedata[0] ##1 ce_i [*2];
	endsequence

	property p_thresh;
		s_wr(6'h00) ##1 ce_i [*2] |->
			analog_o.threshold_sel == $past(avm_i.writedata[2:0], 2);
	endproperty
	a_thresh: assert property (p_thresh)
		else $error("threshold select not passed to analog side");

	property p_rsvd;
		avm_i.read && !avm_o.waitrequest && avm_i.address[7:2] == 6'h00
			|-> avm_o.readdata[31:6] == '0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("unimplemented control bits read nonzero");

	property p_sleep;
		ce_i && power_mode_i == SVM_MODE_SLEEP |=> !analog_o.detector_on;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("detector on in sleep mode");

	property p_bg_lvr;
		ce_i && lvr_enable_i |=> analog_o.bandgap_on;
	endproperty
	a_bg_lvr: assert property (p_bg_lvr)
		else $error("bandgap off while low voltage reset on");

	property p_bg_det;
		analog_o.detector_on |-> analog_o.bandgap_on;
	endproperty
	a_bg_det: assert property (p_bg_det)
		else $error("bandgap off while detector on");

	property p_wake_dly;
		wake_o |-> low_cnt > IRQ_DELAY_CYCLES;
	endproperty
	a_wake_dly: assert property (p_wake_dly)
		else $error("request flag set before the delay ran out");

	property p_wake_pulse;
		wake_o && ce_i |=> !wake_o;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake pulse longer than one cycle");

	property p_glb_off;
		s_wr_off(6'h02) |-> !lvd_irq_o && !irq_o;
	endproperty
	a_glb_off: assert property (p_glb_off)
		else $error("interrupt out with global enable clear");

	property p_lvd_en;
		s_wr_off(6'h01) |-> !lvd_irq_o;
	endproperty
	a_lvd_en: assert property (p_lvd_en)
		else $error("low supply interrupt out while disabled");

	property p_reset;
		$rose(reset_n_i) |-> analog_o == '0 && !wake_o && !lvd_irq_o &&
			!irq_o && avm_o.waitrequest;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not idle after reset");
endmodule

bind svm_top svm_props #(.IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES)) u_props (
	.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
	.avm_i(avm_i), .avm_o(avm_o), .power_mode_i(power_mode_i),
	.lvr_enable_i(lvr_enable_i), .comp_below_i(comp_below_i),
	.analog_o(analog_o), .wake_o(wake_o), .lvd_irq_o(lvd_irq_o),
	.irq_o(irq_o)
);
`default_nettype wire

/* bench/svm_tb.sv */
// self-checking bench for the supply monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench
	import svm_pkg::*;
;
	localparam int unsigned N = 8;
	logic         clk;
	logic         rst_n;
	logic         ce;
	svm_avm_req_s req;
	svm_avm_rsp_s rsp;
	svm_mode_e    mode;
	logic         low_voltage_reset;
	logic         comp;
	svm_analog_s  ana;
	logic         wake;
	logic         lvd_irq;
	logic         irq;
	logic [3:0]   be;
	logic [31:0]  q;
	int           fails = 0;
	int           checks = 0;
	int           wakes = 0;
	int           n;
	// trip levels in millivolts, 2.0 V up to 4.0 V
	logic [15:0]  mv [0:7] = '{16'h07D0, 16'h0898, 16'h0960, 16'h0A8C,
		16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};

	// short delay keeps the interrupt scenarios brief
	svm_top #(.IRQ_DELAY_CYCLES(N)) u_dut (
		.core_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
		.avm_i(req), .avm_o(rsp), .power_mode_i(mode),
		.lvr_enable_i(low_voltage_reset), .comp_below_i(comp), .analog_o(ana),
		.wake_o(wake), .lvd_irq_o(lvd_irq), .irq_o(irq)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// counted on the falling edge, where the one-cycle pulse is settled
	always @(negedge clk) begin
		if (wake === 1'b1)
			wakes++;
	end

	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// one bus cycle; request held until the edge that sees waitrequest low
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		req <= '{!w, w, a, d, be};
		@(posedge clk);
		while (rsp.waitrequest !== 1'b0)
			@(posedge clk);
		q = rsp.readdata;
		req <= '{1'b0, 1'b0, a, d, be};
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0000_0000);
		`CHK($sformatf("reg %0h", a), e, q)
	endtask

	task automatic wt(input int k);
		repeat (k) @(negedge clk);
	endtask

	// whole run is a few hundred cycles; this leaves wide margin
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		end_sim;
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		req = '0;
		be = 4'h1;
		mode = SVM_MODE_FAST;
		low_voltage_reset = 1'b0;
		comp = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rdc(8'h00, 32'h0000_0000);
		rdc(8'h04, 32'h0000_0000);
		for (int c = 0; c < 8; c++) begin
			acc(1'b1, 8'h00, 32'(c));
			rdc(8'h14, {16'h0000, mv[c]});
			`CHK("threshold_sel", 3'(c), ana.threshold_sel)
		end
		acc(1'b1, 8'h00, 32'h0000_00FF);
		rdc(8'h00, 32'h0000_001F);
		wt(2);
		`CHK("detector_on", 1'b1, ana.detector_on)
		// frozen clock enable must hold the detector state
		@(posedge clk);
		ce <= 1'b0;
		mode <= SVM_MODE_SLEEP;
		wt(3);
		`CHK("frozen", 1'b1, ana.detector_on)
		@(posedge clk);
		ce <= 1'b1;
		wt(3);
		`CHK("sleep", 1'b0, ana.detector_on)
		@(posedge clk);
		mode <= SVM_MODE_SLOW;
		wt(3);
		`CHK("slow", 1'b1, ana.detector_on)
		@(posedge clk);
		mode <= SVM_MODE_IDLE;
		wt(3);
		`CHK("idle", 1'b1, ana.detector_on)
		acc(1'b1, 8'h00, 32'h0000_0000);
		wt(3);
		`CHK("detector_off", 1'b0, ana.detector_on)
		`CHK("bandgap_off", 1'b0, ana.bandgap_on)
		@(posedge clk);
		low_voltage_reset <= 1'b1;
		wt(3);
		`CHK("bandgap_lvr", 1'b1, ana.bandgap_on)
		@(posedge clk);
		low_voltage_reset <= 1'b0;
		acc(1'b1, 8'h00, 32'h0000_0008);
		wt(3);
		`CHK("bandgap_buf", 1'b1, ana.bandgap_on)
		acc(1'b1, 8'h00, 32'h0000_0010);
		acc(1'b1, 8'h08, 32'h0000_0001);
		acc(1'b1, 8'h04, 32'h0000_0001);
		acc(1'b1, 8'h10, 32'h0000_0002);
		@(posedge clk);
		comp <= 1'b1;
		n = 0;
		while (wake !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		`CHK("wake_delay", 1'b1, n >= N && n <= N + 8)
		wt(2);
		`CHK("lvd_irq", 1'b1, lvd_irq)
		`CHK("irq", 1'b1, irq)
		rdc(8'h00, 32'h0000_0030);
		rdc(8'h04, 32'h0000_0011);
		rdc(8'h0C, 32'h0000_0003);
		acc(1'b1, 8'h08, 32'h0000_0000);
		wt(2);
		`CHK("lvd_irq_gated", 1'b0, lvd_irq)
		`CHK("irq_gated", 1'b0, irq)
		acc(1'b1, 8'h08, 32'h0000_0001);
		acc(1'b1, 8'h0C, 32'h0000_0007);
		rdc(8'h0C, 32'h0000_0000);
		`CHK("irq_cleared", 1'b0, irq)
		// flag preset with its enable off, so no wake and no lvd_irq; the low rise event still raises irq
		acc(1'b1, 8'h04, 32'h0000_0010);
		@(posedge clk);
		comp <= 1'b0;
		wt(4);
		rdc(8'h00, 32'h0000_0010);
		rdc(8'h0C, 32'h0000_0004);
		n = wakes;
		@(posedge clk);
		comp <= 1'b1;
		wt(N + 20);
		`CHK("no_wake", n, wakes)
		rdc(8'h00, 32'h0000_0030);
		rdc(8'h3C, 32'h0000_0000);
		acc(1'b1, 8'h3C, 32'h0000_00FF);
		be = 4'h0;
		acc(1'b1, 8'h00, 32'h0000_0007);
		be = 4'h1;
		rdc(8'h00, 32'h0000_0030);
		end_sim;
	end
endmodule
`default_nettype wire
